// file: design/actc_clock_tree.sv
/*
  Audio clock tree configuration core: control-port registers for the
  master-mode divider resets, pll reference and converter clock source
  selection, pll factors and the clock resync request, plus the decoded
  clock tree controls that follow from them.
  Assumes the control port presents one byte access per clock cycle,
  that auto-mode choices and pll_enable come from logic on clk, and that
  the frame clock pin is asynchronous.
*/
// How it works
// R1 - bit 1 low holds bit-clock divider reset
// R2 - bit 0 low holds frame-clock divider reset
// R3 - software releases and programs dividers first
// R4 - reference select: master pin or general pin
// R5 - auto mode overrides reference select
// R6 - converter source: auto, pll, pin, bitclock
// R7 - undefined converter source code mutes clock
// R8 - pin select code 010 picks pin one
// R9 - resync bit high halts converter clocks
// R10 - resync cleared resumes clocks at frame
// R11 - pre-divider is code plus one, 1111 banned (dropped on register writes only; auto mode passes 1111 and p wraps to 0)
// R12 - integer multiplier equals code, zero banned (dropped on register writes only; reset loads 0 and auto mode passes 0)
// R13 - fraction is fourteen bits, up to 9999
// R14 - post-multiplier is code plus one
// R15 - pll disabled makes master clock the pin
// R16 - pll ratio: (j + d/10000) * r over p
`timescale 1ns/1ps
module actc_clock_tree (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control port register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // automatic clock setup choices
  input  wire logic        auto_mode,
  input  wire logic [2:0]  auto_ref_sel,
  input  wire logic [3:0]  auto_pre_div,
  input  wire logic [4:0]  auto_int_mult,
  input  wire logic [13:0] auto_fraction,
  input  wire logic [3:0]  auto_post_mult,
  // pll enable from the power control logic
  input  wire logic        pll_enable,
  // frame clock pin
  input  wire logic        frame_clock_pin,
  // master-mode divider controls
  output logic             bit_div_run,
  output logic             frame_div_run,
  // pll reference routing
  output logic             ref_from_mclk,
  output logic             ref_from_general_pin_one,
  output logic             ref_invalid,
  output logic             master_from_pll,
  // converter clock source routing
  output logic             conv_from_pll,
  output logic             conv_from_mclk,
  output logic             conv_from_bitclk,
  output logic             conv_clk_mute,
  // pll factors in effect
  output logic      [3:0]  pll_pre_div,
  output logic      [23:0] pll_ratio,
  // resync-controlled clocks
  output logic             dac_clk_run,
  output logic             charge_pump_clock_run,
  output logic             oversampling_clock_run,
  output logic             resync_restart
);

  // all state of this module
  typedef struct packed {
    logic [7:0]  div_reset;     // master divider reset register
    logic [7:0]  ref_sel;       // pll reference select register
    logic [7:0]  conv_src;      // converter clock source register
    logic [7:0]  pin_sel;       // reference pin select register
    logic [7:0]  resync;        // resync request register
    logic [7:0]  pre_div;       // pll pre-divider register
    logic [7:0]  int_mult;      // pll integer multiplier register
    logic [7:0]  frac_hi;       // fraction upper byte
    logic [7:0]  frac_lo;       // fraction lower byte
    logic [7:0]  post_mult;     // pll post-multiplier register

    // read port
    logic [7:0]  rdata;         // read data
    logic        rvalid;        // read answer strobe

    // decoded divider controls
    logic        bit_run;
    logic        frame_run;

    // pll reference routing
    logic        ref_mclk;
    logic        ref_pin1;
    logic        ref_bad;
    logic        mclk_pll;

    // converter clock routing
    logic        c_pll;
    logic        c_mclk;
    logic        c_bclk;
    logic        c_mute;

    // pll factors in effect
    logic [3:0]  p_div;
    logic [23:0] ratio;

    // resync-controlled clocks
    logic        dac_run;
    logic        pump_run;
    logic        ovs_run;
    logic        restart;
  } actc_core_st_t;

  actc_core_st_t s_reg;
  actc_core_st_t s_next;

  // decoded working values
  logic [2:0]  ref_code;        // reference code in effect
  logic [2:0]  conv_code;       // converter source code
  logic [3:0]  p_code;          // pre-divider code in effect
  logic [4:0]  j_code;          // integer multiplier in effect
  logic [13:0] d_val;           // fraction in effect
  logic [3:0]  r_code;          // post-multiplier code in effect
  logic        auto_pick_pll;   // auto master clock choice

  // carrier to the resync sequencer
  actc_rsy_if rsy ();

  // read mux over the register map; unmapped reads as zero
  function automatic logic [7:0] read_mux(input actc_core_st_t st,
                                          input logic [7:0]    a);
    logic [7:0] v;

    v = 8'h00;
    case (a)
      actc_pkg::OFS_DIV_RESET: v = st.div_reset;
      actc_pkg::OFS_REF_SEL:   v = st.ref_sel;
      actc_pkg::OFS_CONV_SRC:  v = st.conv_src;
      actc_pkg::OFS_PIN_SEL:   v = st.pin_sel;
      actc_pkg::OFS_RESYNC:    v = st.resync;
      actc_pkg::OFS_PRE_DIV:   v = st.pre_div;
      actc_pkg::OFS_INT_MULT:  v = st.int_mult;
      actc_pkg::OFS_FRAC_HI:   v = st.frac_hi;
      actc_pkg::OFS_FRAC_LO:   v = st.frac_lo;
      actc_pkg::OFS_POST_MULT: v = st.post_mult;
      default:                 v = 8'h00;
    endcase

    return v;
  endfunction

  // clamp a raw fraction into its decimal range
  function automatic logic [13:0] clamp_frac(input logic [13:0] raw);
    logic [13:0] v;

    v = raw;
    if (raw > actc_pkg::FRAC_MAX) begin
      v = actc_pkg::FRAC_MAX;
    end

    return v;
  endfunction

  // overall multiplication (j * 10000 + d) * (r + 1)
  function automatic logic [23:0] calc_ratio(input logic [4:0]  j,
                                             input logic [13:0] d,
                                             input logic [3:0]  rc);
    logic [19:0] jd;
    logic [23:0] prod;

    jd   = 20'(j) * actc_pkg::FRAC_SCALE + 20'(d);
    prod = 24'(jd) * (24'(rc) + 24'h000001);
    return prod;
  endfunction

  // resync sequencing lives in its own small module
  actc_resync_seq u_resync (
    .clk             (clk),
    .rst_n           (rst_n),
    .frame_clock_pin (frame_clock_pin),
    .rsy             (rsy.seq)
  );

  assign rsy.hold_req = s_reg.resync[actc_pkg::BIT_RESYNC]; // R9

  // next state: register writes, reads and decoded outputs
  always_comb begin
    s_next = s_reg;

    // register writes from the control port
    if (reg_wr) begin
      case (reg_addr)
        actc_pkg::OFS_DIV_RESET: s_next.div_reset = reg_wdata;
        actc_pkg::OFS_REF_SEL:   s_next.ref_sel   = reg_wdata;
        actc_pkg::OFS_CONV_SRC:  s_next.conv_src  = reg_wdata;
        actc_pkg::OFS_PIN_SEL:   s_next.pin_sel   = reg_wdata;
        actc_pkg::OFS_RESYNC:    s_next.resync    = reg_wdata;
        actc_pkg::OFS_PRE_DIV: begin
          // the banned code would leave the pll undefined; drop it
          if (reg_wdata[3:0] != actc_pkg::PRE_DIV_BAN) begin
            s_next.pre_div = reg_wdata; // R11
          end
        end
        actc_pkg::OFS_INT_MULT: begin
          // a zero multiplier would stop the pll; drop it
          if (reg_wdata[4:0] != actc_pkg::INT_MULT_BAN) begin
            s_next.int_mult = reg_wdata; // R12
          end
        end
        actc_pkg::OFS_FRAC_HI:   s_next.frac_hi   = reg_wdata;
        actc_pkg::OFS_FRAC_LO:   s_next.frac_lo   = reg_wdata;
        actc_pkg::OFS_POST_MULT: s_next.post_mult = reg_wdata;
        default: begin
          // unmapped write is ignored
        end
      endcase
    end

    // read answer one cycle after the request
    s_next.rvalid = reg_rd;
    if (reg_rd) begin
      s_next.rdata = read_mux(s_reg, reg_addr);
    end

    // master-mode divider resets, active low in the register
    s_next.bit_run   = s_reg.div_reset[actc_pkg::BIT_BCLK_RUN]; // R1
    s_next.frame_run = s_reg.div_reset[actc_pkg::BIT_FCLK_RUN]; // R2

    // reference select, overridden in auto mode
    if (auto_mode) begin
      ref_code = auto_ref_sel; // R5
    end else begin
      ref_code = s_reg.ref_sel[actc_pkg::REF_SEL_LSB +: 3]; // R4
    end
    s_next.ref_mclk = (ref_code == actc_pkg::REF_MCLK_A) ||
                      (ref_code == actc_pkg::REF_MCLK_B); // R4
    // only pin one is a legal reference pin
    s_next.ref_pin1 = (ref_code == actc_pkg::REF_GPIO) &&
                      (s_reg.pin_sel[actc_pkg::PIN_SEL_LSB +: 3] ==
                       actc_pkg::PIN_GP_ONE); // R8
    // reserved codes leave the pll without a reference
    s_next.ref_bad  = !s_next.ref_mclk && !s_next.ref_pin1; // R4

    // master clock follows pll enable
    auto_pick_pll   = pll_enable; // R15
    s_next.mclk_pll = auto_pick_pll; // R15

    // converter clock source select
    conv_code     = s_reg.conv_src[actc_pkg::CONV_SRC_LSB +: 3];
    s_next.c_pll  = 1'b0;
    s_next.c_mclk = 1'b0;
    s_next.c_bclk = 1'b0;
    s_next.c_mute = 1'b0;
    case (conv_code)
      actc_pkg::CONV_AUTO: begin
        // auto master clock: pll when enabled, else the pin
        s_next.c_pll  = auto_pick_pll;  // R6
        s_next.c_mclk = !auto_pick_pll; // R6
      end
      actc_pkg::CONV_PLL:  s_next.c_pll  = 1'b1; // R6
      actc_pkg::CONV_MCLK: s_next.c_mclk = 1'b1; // R6
      actc_pkg::CONV_BCLK: s_next.c_bclk = 1'b1; // R6
      default:             s_next.c_mute = 1'b1; // R7
    endcase

    // pll factors, auto choices replace the registers
    if (auto_mode) begin
      p_code = auto_pre_div;   // R11
      j_code = auto_int_mult;  // R12
      d_val  = clamp_frac(auto_fraction); // R13
      r_code = auto_post_mult; // R14
    end else begin
      p_code = s_reg.pre_div[3:0];  // R11
      j_code = s_reg.int_mult[4:0]; // R12
      d_val  = clamp_frac({s_reg.frac_hi[actc_pkg::FRAC_HI_BITS-1:0],
                           s_reg.frac_lo}); // R13
      r_code = s_reg.post_mult[3:0]; // R14
    end
    // reset codes give p of one, pre-divider value is code plus one
    s_next.p_div = p_code + 4'h1; // R11
    s_next.ratio = calc_ratio(j_code, d_val, r_code); // R16

    // resync-controlled clocks, one flop after the sequencer
    s_next.dac_run = rsy.clocks_run; // R9
    s_next.pump_run = rsy.clocks_run; // R9
    s_next.ovs_run  = rsy.clocks_run; // R9
    s_next.restart = rsy.restart;    // R10
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg           <= '0;

      s_reg.div_reset <= actc_pkg::RST_DIV_RESET;
      s_reg.ref_sel   <= actc_pkg::RST_REF_SEL;
      s_reg.conv_src  <= actc_pkg::RST_CONV_SRC;
      s_reg.pin_sel   <= actc_pkg::RST_PIN_SEL;
      s_reg.resync    <= actc_pkg::RST_RESYNC;
      s_reg.pre_div   <= actc_pkg::RST_PRE_DIV;
      s_reg.int_mult  <= actc_pkg::RST_INT_MULT;
      s_reg.frac_hi   <= actc_pkg::RST_FRAC_HI;
      s_reg.frac_lo   <= actc_pkg::RST_FRAC_LO;
      s_reg.post_mult <= actc_pkg::RST_POST_MULT;

      s_reg.p_div     <= 4'h1;
      s_reg.dac_run   <= 1'b1;
      s_reg.pump_run  <= 1'b1;
      s_reg.ovs_run   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata                = s_reg.rdata;
  assign reg_rvalid               = s_reg.rvalid;

  assign bit_div_run              = s_reg.bit_run;
  assign frame_div_run            = s_reg.frame_run;

  assign ref_from_mclk            = s_reg.ref_mclk;
  assign ref_from_general_pin_one = s_reg.ref_pin1;
  assign ref_invalid              = s_reg.ref_bad;
  assign master_from_pll          = s_reg.mclk_pll;

  assign conv_from_pll            = s_reg.c_pll;
  assign conv_from_mclk           = s_reg.c_mclk;
  assign conv_from_bitclk         = s_reg.c_bclk;
  assign conv_clk_mute            = s_reg.c_mute;

  assign pll_pre_div              = s_reg.p_div;
  assign pll_ratio                = s_reg.ratio;

  assign dac_clk_run              = s_reg.dac_run;
  assign charge_pump_clock_run    = s_reg.pump_run;
  assign oversampling_clock_run   = s_reg.ovs_run;
  assign resync_restart           = s_reg.restart;

endmodule

// file: design/actc_pkg.sv
/*
  Shared constants for the audio clock tree configuration block:
  register offsets, reset values, field positions, select codes and
  the resync sequencer state type.
  Assumes nothing of its surroundings; compiled before every other file.
*/
package actc_pkg;

  // register offsets on the control port
  localparam logic [7:0] OFS_DIV_RESET = 8'h0C;
  localparam logic [7:0] OFS_REF_SEL   = 8'h0D;
  localparam logic [7:0] OFS_CONV_SRC  = 8'h0E;
  localparam logic [7:0] OFS_PIN_SEL   = 8'h12;
  localparam logic [7:0] OFS_RESYNC    = 8'h13;
  localparam logic [7:0] OFS_PRE_DIV   = 8'h14;
  localparam logic [7:0] OFS_INT_MULT  = 8'h15;
  localparam logic [7:0] OFS_FRAC_HI   = 8'h16;
  localparam logic [7:0] OFS_FRAC_LO   = 8'h17;
  localparam logic [7:0] OFS_POST_MULT = 8'h18;

  // reset values
  localparam logic [7:0] RST_DIV_RESET = 8'h7C;
  localparam logic [7:0] RST_REF_SEL   = 8'h00;
  localparam logic [7:0] RST_CONV_SRC  = 8'h00;
  localparam logic [7:0] RST_PIN_SEL   = 8'h00;
  localparam logic [7:0] RST_RESYNC    = 8'h10;
  localparam logic [7:0] RST_PRE_DIV   = 8'h00;
  localparam logic [7:0] RST_INT_MULT  = 8'h00;
  localparam logic [7:0] RST_FRAC_HI   = 8'h00;
  localparam logic [7:0] RST_FRAC_LO   = 8'h00;
  localparam logic [7:0] RST_POST_MULT = 8'h00;

  // field positions
  localparam int BIT_BCLK_RUN  = 1;
  localparam int BIT_FCLK_RUN  = 0;
  localparam int REF_SEL_LSB   = 4;
  localparam int CONV_SRC_LSB  = 4;
  localparam int PIN_SEL_LSB   = 0;
  localparam int BIT_RESYNC    = 0;
  localparam int FRAC_HI_BITS  = 6;

  // pll reference codes
  localparam logic [2:0] REF_MCLK_A = 3'h0;
  localparam logic [2:0] REF_MCLK_B = 3'h1;
  localparam logic [2:0] REF_GPIO   = 3'h7;
  localparam logic [2:0] PIN_GP_ONE = 3'h2;

  // converter clock source codes
  localparam logic [2:0] CONV_AUTO = 3'h0;
  localparam logic [2:0] CONV_PLL  = 3'h1;
  localparam logic [2:0] CONV_MCLK = 3'h3;
  localparam logic [2:0] CONV_BCLK = 3'h4;

  // forbidden factor codes and fraction limits
  localparam logic [3:0]  PRE_DIV_BAN  = 4'hF;
  localparam logic [4:0]  INT_MULT_BAN = 5'h00;
  localparam logic [13:0] FRAC_MAX     = 14'h270F;
  localparam logic [19:0] FRAC_SCALE   = 20'h02710;

  // resync sequencer states, gray along run -> halt -> wait
  typedef enum logic [1:0] {
    ACTC_RUN  = 2'b00,
    ACTC_HALT = 2'b01,
    ACTC_WAIT = 2'b11
  } actc_rsy_t;

endpackage

// file: design/actc_rsy_if.sv
/*
  Carrier between the register core and the resync sequencer.
  Assumes both ends run on the same clk.
*/
`timescale 1ns/1ps
interface actc_rsy_if;
  logic hold_req;    // resync bit as stored
  logic clocks_run;  // converter, pump, oversampling clocks running
  logic restart;     // one-cycle pulse when clocks resume
  modport seq (input hold_req, output clocks_run, output restart);
  modport ctl (output hold_req, input clocks_run, input restart);
endinterface

// file: design/actc_resync_seq.sv
/*
  Resync sequencer: halts the converter, charge pump and oversampling
  clocks while the resync bit is set, then resumes them on the next
  frame start seen on the frame clock pin.
  Assumes frame_clock_pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module actc_resync_seq (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // frame clock pin
  input  wire logic      frame_clock_pin,
  // link to the register core
  actc_rsy_if.seq        rsy
);

  typedef struct packed {
    logic               sync1;   // first synchroniser stage
    logic               sync2;   // second synchroniser stage
    logic               prev;    // delayed copy for edge detect
    actc_pkg::actc_rsy_t state;
    logic               run;
    logic               restart;
  } actc_seq_st_t;

  actc_seq_st_t s_reg;
  actc_seq_st_t s_next;
  logic         frame_start;     // rising edge of frame clock

  // next state
  always_comb begin
    s_next         = s_reg;
    s_next.sync1   = frame_clock_pin;
    s_next.sync2   = s_reg.sync1;
    s_next.prev    = s_reg.sync2;
    s_next.restart = 1'b0;
    frame_start    = s_reg.sync2 & ~s_reg.prev;
    case (s_reg.state)
      actc_pkg::ACTC_RUN: begin
        // halt at once on request
        if (rsy.hold_req) begin
          s_next.state = actc_pkg::ACTC_HALT; // R9
          s_next.run   = 1'b0;                // R9
        end
      end
      actc_pkg::ACTC_HALT: begin
        // stay halted until the bit returns to 0
        if (!rsy.hold_req) begin
          s_next.state = actc_pkg::ACTC_WAIT;
        end
      end
      actc_pkg::ACTC_WAIT: begin
        // a fresh request wins over a frame start
        if (rsy.hold_req) begin
          s_next.state = actc_pkg::ACTC_HALT;
        end else if (frame_start) begin
          s_next.state   = actc_pkg::ACTC_RUN; // R10
          s_next.run     = 1'b1;               // R10
          s_next.restart = 1'b1;
        end
      end
      default: begin
        s_next.state = actc_pkg::ACTC_HALT;
        s_next.run   = 1'b0;
      end
    endcase
  end

  // state register, clocks run from reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0,
                 state: actc_pkg::ACTC_RUN, run: 1'b1, restart: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsy.clocks_run = s_reg.run;
  assign rsy.restart    = s_reg.restart;

endmodule

// file: verif/actc_monitor.sv
/*
  Port checker for the audio clock tree configuration core.
  Assumes it is bound to actc_clock_tree and sees only its top ports.
*/
`timescale 1ns/1ps
module actc_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid,
  // auto, pll and pin inputs
  input wire logic       auto_mode,
  input wire logic [2:0] auto_ref_sel,
  input wire logic       pll_enable,
  input wire logic       frame_clock_pin,
  // decoded controls
  input wire logic       bit_div_run,
  input wire logic       frame_div_run,
  input wire logic       ref_from_mclk,
  input wire logic       ref_from_general_pin_one,
  input wire logic       ref_invalid,
  input wire logic       master_from_pll,
  input wire logic       conv_from_pll,
  input wire logic       conv_from_mclk,
  input wire logic       conv_from_bitclk,
  input wire logic       conv_clk_mute,
  input wire logic [3:0] pll_pre_div,
  // resync-controlled clocks
  input wire logic       dac_clk_run,
  input wire logic       charge_pump_clock_run,
  input wire logic       oversampling_clock_run,
  input wire logic       resync_restart
);
  // single domain, so one clock and one disable for all
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  // read answer lands exactly one cycle after its strobe
  AST_RVALID: assert property ($past(rst_n) |-> reg_rvalid == $past(reg_rd))
    else $error("read valid late");
  // a lone write to the divider register shows two cycles on
  AST_BIT_DIV: assert property (
    (reg_wr && reg_addr == 8'h0C) ##1 !(reg_wr && reg_addr == 8'h0C)
    |=> bit_div_run == $past(reg_wdata[1], 2))
    else $error("bit divider run wrong");
  AST_FRAME_DIV: assert property (
    (reg_wr && reg_addr == 8'h0C) ##1 !(reg_wr && reg_addr == 8'h0C)
    |=> frame_div_run == $past(reg_wdata[0], 2))
    else $error("frame divider run wrong");
  // one reference route once decoding has loaded
  AST_REF_ONEHOT: assert property ($past(rst_n) |->
    $onehot({ref_from_mclk, ref_from_general_pin_one, ref_invalid}))
    else $error("reference not one-hot");
  // auto choice of master pin wins over whatever the register holds
  AST_AUTO_REF: assert property (
    (auto_mode && auto_ref_sel == 3'h0) [*3] |-> ref_from_mclk)
    else $error("auto reference choice ignored");
  AST_CONV_ONEHOT: assert property ($past(rst_n) |-> $onehot(
    {conv_from_pll, conv_from_mclk, conv_from_bitclk, conv_clk_mute}))
    else $error("converter not one-hot");
  // a banned code 1111 would make the divide value wrap to zero
  AST_PRE_DIV: assert property (
    $past(rst_n) && !auto_mode && !$past(auto_mode) |-> pll_pre_div != 4'h0)
    else $error("pll pre-divider out of range");
  AST_MASTER: assert property (
    $past(rst_n) |-> master_from_pll == $past(pll_enable))
    else $error("master source wrong");
  AST_HALT: assert property (
    reg_wr && reg_addr == 8'h13 && reg_wdata[0] |-> ##[1:3] !dac_clk_run)
    else $error("clocks not halted");
  AST_RUNS_TIED: assert property (
    dac_clk_run == charge_pump_clock_run
    && dac_clk_run == oversampling_clock_run)
    else $error("resync clocks disagree");
  AST_RESTART: assert property ($rose(dac_clk_run) |-> resync_restart)
    else $error("clocks resumed without restart pulse");
  // resume only close behind a frame start, and only as a pulse
  AST_FRAME_ALIGN: assert property (
    resync_restart |-> $past(frame_clock_pin, 2)
    && !$past(frame_clock_pin, 6) ##1 !resync_restart)
    else $error("restart not aligned to frame start");
endmodule

bind actc_clock_tree actc_monitor u_mon (
  .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
  .auto_mode, .auto_ref_sel, .pll_enable, .frame_clock_pin, .bit_div_run,
  .frame_div_run, .ref_from_mclk, .ref_from_general_pin_one, .ref_invalid,
  .master_from_pll, .conv_from_pll, .conv_from_mclk, .conv_from_bitclk,
  .conv_clk_mute, .pll_pre_div, .dac_clk_run, .charge_pump_clock_run,
  .oversampling_clock_run, .resync_restart);

// file: verif/tb_top.sv
/*
  Self-checking bench for the audio clock tree configuration core.
  Assumes the core and its package are compiled first; no partner model.
*/
`timescale 1ns/1ps
module tb_top;
  // stimulus, all valued at time zero
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic        auto_mode = 1'b0, pll_enable = 1'b1, frame_clock_pin = 1'b0;
  logic [2:0]  auto_ref_sel = 3'h0;
  logic [3:0]  auto_pre_div = 4'h0, auto_post_mult = 4'h0;
  logic [4:0]  auto_int_mult = 5'h01;
  logic [13:0] auto_fraction = 14'h0000;
  // observed outputs
  logic [7:0]  reg_rdata;
  logic        reg_rvalid, bit_div_run, frame_div_run, ref_from_mclk;
  logic        ref_from_general_pin_one, ref_invalid, master_from_pll;
  logic        conv_from_pll, conv_from_mclk, conv_from_bitclk;
  logic        conv_clk_mute, dac_clk_run, charge_pump_clock_run;
  logic        oversampling_clock_run, resync_restart;
  logic [3:0]  pll_pre_div;
  logic [23:0] pll_ratio;
  // bookkeeping
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  // 50 ns period
  always #25 clk = ~clk;

  actc_clock_tree DUT (
    .clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .auto_mode, .auto_ref_sel, .auto_pre_div, .auto_int_mult,
    .auto_fraction, .auto_post_mult, .pll_enable, .frame_clock_pin,
    .bit_div_run, .frame_div_run, .ref_from_mclk, .ref_from_general_pin_one,
    .ref_invalid, .master_from_pll, .conv_from_pll, .conv_from_mclk,
    .conv_from_bitclk, .conv_clk_mute, .pll_pre_div, .pll_ratio,
    .dac_clk_run, .charge_pump_clock_run, .oversampling_clock_run,
    .resync_restart);

  // n edges, then step off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // trailing edge keeps two strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  // answer is looked at in the one cycle it stands
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    step(1);
    reg_rd = 1'b0;
    chk(24'({reg_rvalid, reg_rdata}), {15'h0, 1'b1, e});
    step(1);
  endtask

  // reset values of every register, plus an unmapped offset
  task automatic t_reset;
    logic [7:0] ofs [11] = '{8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h13, 8'h14,
                             8'h15, 8'h16, 8'h17, 8'h18, 8'h20};
    chk(24'({bit_div_run, frame_div_run, dac_clk_run}), 24'h1);
    chk({ref_from_mclk, pll_pre_div, pll_ratio[18:0]}, 24'h880000);
    for (int i = 0; i < 11; i++) begin
      rd_chk(ofs[i], (i == 0) ? 8'h7C : (i == 4) ? 8'h10 : 8'h00);
    end
  endtask

  // divider resets released one at a time
  task automatic t_div;
    wr(8'h0C, 8'h02);
    chk(24'({bit_div_run, frame_div_run}), 24'h2);
    wr(8'h0C, 8'h01);
    chk(24'({bit_div_run, frame_div_run}), 24'h1);
    rd_chk(8'h0C, 8'h01);
    wr(8'h0C, 8'h03);
  endtask

  // reference codes, pin select and the auto override
  task automatic t_ref;
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h4, 3'h7, 3'h7};
    logic [2:0] pin [5] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h0};
    logic [2:0] ex [5] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h1};
    for (int i = 0; i < 5; i++) begin
      wr(8'h12, {5'h00, pin[i]});
      wr(8'h0D, {1'b0, code[i], 4'h0});
      chk(24'({ref_from_mclk, ref_from_general_pin_one, ref_invalid}),
          24'(ex[i]));
    end
    auto_mode = 1'b1;
    step(3);
    chk(24'(ref_from_mclk), 24'h1);
    auto_mode = 1'b0;
  endtask

  // every converter source code, then pll switched off
  task automatic t_conv;
    logic [3:0] ex [8] = '{4'h8, 4'h8, 4'h1, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1};
    for (int c = 0; c < 8; c++) begin
      wr(8'h0E, {1'b0, 3'(c), 4'h0});
      chk(24'({conv_from_pll, conv_from_mclk, conv_from_bitclk,
               conv_clk_mute}), 24'(ex[c]));
    end
    pll_enable = 1'b0;
    wr(8'h0E, 8'h00);
    chk(24'({master_from_pll, conv_from_mclk}), 24'h1);
    pll_enable = 1'b1;
  endtask

  // factors at their limits, banned codes, clamp, auto values
  task automatic t_pll;
    wr(8'h14, 8'h0E);
    wr(8'h14, 8'h0F);
    chk(24'(pll_pre_div), 24'hF);
    rd_chk(8'h14, 8'h0E);
    wr(8'h15, 8'h1F);
    wr(8'h15, 8'h00);
    rd_chk(8'h15, 8'h1F);
    wr(8'h16, 8'h27);
    wr(8'h17, 8'h0F);
    wr(8'h18, 8'h0F);
    chk(pll_ratio, 24'h4E1FF0);
    wr(8'h16, 8'h3F);
    wr(8'h17, 8'hFF);
    chk(pll_ratio, 24'h4E1FF0);
    auto_pre_div = 4'h1;
    auto_int_mult = 5'h05;
    auto_post_mult = 4'h1;
    auto_fraction = 14'h3FFF;
    auto_mode = 1'b1;
    step(3);
    chk({pll_pre_div, pll_ratio[19:0]}, 24'h21D4BE);
    auto_mode = 1'b0;
  endtask

  // halt, ignore frames while held, resume on the next frame start
  task automatic t_resync;
    int n;
    wr(8'h13, 8'h01);
    step(1);
    chk(24'({dac_clk_run, resync_restart}), 24'h0);
    frame_clock_pin = 1'b1;
    step(8);
    chk(24'(dac_clk_run), 24'h0);
    frame_clock_pin = 1'b0;
    wr(8'h13, 8'h00);
    step(8);
    chk(24'(dac_clk_run), 24'h0);
    frame_clock_pin = 1'b1;
    n = 0;
    while (resync_restart !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    chk(24'({resync_restart, dac_clk_run, charge_pump_clock_run,
             oversampling_clock_run}), 24'hF);
    step(1);
    chk(24'({resync_restart, dac_clk_run}), 24'h1);
    frame_clock_pin = 1'b0;
  endtask

  task automatic close_out;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(1);
    t_reset();
    t_div();
    t_ref();
    t_conv();
    t_pll();
    t_resync();
    close_out();
  end
endmodule
